//--- sli_checker.sv
// checker: port-level assertions for the status lamp indicator
`timescale 1ns/10ps
`default_nettype none
module sli_checker
(
    input wire logic                  i_clk,
    input wire logic                  i_sys_rst,
    input wire sli_pkg::sli_status_t  i_status,
    input wire logic                  i_corr_msg_stb,
    input wire logic                  i_gp_func_we,
    input wire sli_pkg::sli_gp_func_t i_gp_func,
    input wire logic                  i_power_mode_command,
    input wire logic                  i_wakeup_serial_port_rx,
    input wire logic                  i_power_fail,
    input wire sli_pkg::sli_lamps_t   o_lamps,
    input wire logic                  o_standby,
    input wire logic                  o_card_write_enable
);
    import sli_pkg::*;
    logic seen_r;
    logic seen_nxt;
    logic gp_set_r;
    logic gp_set_nxt;
    // ----------------
    // helper state
    // ----------------
    always_comb
    begin
        seen_nxt   = seen_r | i_corr_msg_stb;
        gp_set_nxt = gp_set_r | i_gp_func_we;
    end
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            seen_r   <= 1'b0;
            gp_set_r <= 1'b0;
        end
        else
        begin
            seen_r   <= seen_nxt;
            gp_set_r <= gp_set_nxt;
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // awake over two samples, so lamps track inputs
    sequence s_awake;
        !$past(i_sys_rst) && !o_standby && !$past(o_standby);
    endsequence
    sequence s_wake_req;
        o_standby && $fell(i_wakeup_serial_port_rx);
    endsequence
    property p_power;
        !$past(i_sys_rst) |-> o_lamps.power_indicator == $past(i_status.powered_on);
    endproperty
    a_power: assert property (p_power) else $error("power lamp wrong");
    property p_log;
        s_awake |-> o_lamps.logging_indicator == $past(i_status.card_write);
    endproperty
    a_log: assert property (p_log) else $error("logging lamp wrong");
    property p_cwe;
        !$past(i_sys_rst) && $stable(o_standby) |-> o_card_write_enable ==
            $past(i_status.card_write && !i_power_fail && !o_standby);
    endproperty
    a_cwe: assert property (p_cwe) else $error("card write enable wrong");
    property p_enter;
        !o_standby && i_power_mode_command |=> o_standby;
    endproperty
    a_enter: assert property (p_enter) else $error("standby not entered");
    property p_wake;
        s_wake_req |-> ##[1:6] !o_standby;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on serial");
    property p_dark;
        o_standby |-> o_lamps[5:0] == 6'h00;
    endproperty
    a_dark: assert property (p_dark) else $error("lamp lit in standby");
    property p_base;
        s_awake ##0 $past(i_status.base_station) |-> o_lamps.correction_count_indicator;
    endproperty
    a_base: assert property (p_base) else $error("base lamp not solid");
    property p_corr_dark;
        !seen_r && !$past(i_status.base_station) && !$past(i_sys_rst)
            |-> !o_lamps.correction_count_indicator;
    endproperty
    a_corr_dark: assert property (p_corr_dark) else $error("correction lamp early");
    property p_gp_default;
        !gp_set_r && !$past(i_sys_rst)
            |-> o_lamps.general_purpose_indicator == o_lamps.correction_count_indicator;
    endproperty
    a_gp_default: assert property (p_gp_default) else $error("gp default wrong");
endmodule
bind sli_status_led_indicator sli_checker i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_status(i_status), .i_corr_msg_stb(i_corr_msg_stb), .i_gp_func_we(i_gp_func_we),
    .i_gp_func(i_gp_func), .i_power_mode_command(i_power_mode_command),
    .i_wakeup_serial_port_rx(i_wakeup_serial_port_rx), .i_power_fail(i_power_fail),
    .o_lamps(o_lamps), .o_standby(o_standby), .o_card_write_enable(o_card_write_enable));
`default_nettype wire

//--- sli_panel_model.sv
// partner: operator terminal on the wake-up line and a lamp watcher
`timescale 1ns/10ps
`default_nettype none
module sli_panel_model
#(
    parameter int unsigned BIT_CYC = 8
)
(
    input  wire logic                i_clk,
    input  wire sli_pkg::sli_lamps_t i_lamps,
    input  wire logic                i_send,
    output var  logic                o_rx,
    output var  logic                o_busy,
    output var  int unsigned         o_rises
);
    import sli_pkg::*;
    logic [9:0] frame;
    logic       prev;
    initial
    begin
        o_rx = 1'b1;
        o_busy = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_send)
            begin
                o_busy <= 1'b1;
                frame = {1'b1, 8'h0d, 1'b0};
                for (int b = 0; b < 10; b++)
                begin
                    o_rx <= frame[b];
                    repeat (BIT_CYC) @(posedge i_clk);
                end
                o_busy <= 1'b0;
            end
        end
    end
    // count correction lamp turn-ons seen by the operator
    initial
    begin
        o_rises = 0;
        prev = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_lamps.correction_count_indicator && !prev)
                o_rises++;
            prev = i_lamps.correction_count_indicator;
        end
    end
endmodule
`default_nettype wire

//--- sli_pkg.sv
// package: constants and carrier types for the status lamp indicator
package sli_pkg;
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned FLASH_ON_MS      = 150;
    localparam int unsigned FLASH_OFF_MS     = 250;
    localparam int unsigned GROUP_PAUSE_MS   = 1200;
    localparam int unsigned FAST_HALF_MS     = 50;
    localparam int unsigned ACT_HOLD_MS      = 30;
    localparam int unsigned MS_CYCLES        = CLK_HZ / 1000;
    localparam int unsigned CNT_W            = 16;
    localparam logic [7:0]  SAT_RESET        = 8'h00;
    localparam logic [2:0]  GROUPS_MAX       = 3'h5;
    localparam logic [1:0]  GP_FUNC_RESET    = 2'h0;

    typedef enum logic [1:0] {
        SLI_GP_CORRECTION,
        SLI_GP_TRACKING,
        SLI_GP_FIX,
        SLI_GP_OFF
    } sli_gp_func_t;

    typedef struct packed {
        logic       powered_on;
        logic       eth_frame;
        logic       card_write;
        logic       pvt_valid;
        logic       base_station;
        logic       corr_valid;
        logic [7:0] corr_sats;
        logic [7:0] track_sats;
    } sli_status_t;

    typedef struct packed {
        logic power_indicator;
        logic network_activity_indicator;
        logic logging_indicator;
        logic position_fix_indicator;
        logic general_purpose_indicator;
        logic correction_count_indicator;
        logic tracking_indicator;
    } sli_lamps_t;
endpackage

//--- sli_status_led_indicator.sv
// status lamp indicator: front-panel lamps, blink-group encoding, stand-by control
//
// Summary of operation
// - The power lamp is lit for as long as the receiver is switched on.
// - The network activity lamp blinks while Ethernet frames are sent or received.
// - The logging lamp is lit while data is being written to the memory card.
// - The position-fix lamp is lit while a position, velocity and time solution exists.
// - The general-purpose lamp has a selectable function, defaulting to the correction count.
// - In rover mode the correction lamp shows the satellite count of the last correction.
// - Outside base-station mode the correction lamp stays dark until a correction message has been received.
// - A correction count of zero gives a continuous blink at ten flashes per second.
// - Nonzero counts give groups of one to five blinks: 1-2 one, each pair one more, 9+ five.
// - The tracking lamp uses the same encoding for the number of satellites in tracking.
// - A power-mode command requesting stand-by puts the receiver into stand-by.
// - Characters on the first serial port wake the receiver; the operator keeps it reachable.
// - Card logging is guarded against power loss so no unmount is needed.
`timescale 1ns/10ps
`default_nettype none

module sli_status_led_indicator
#(
    parameter int unsigned FLASH_ON_CYC   = sli_pkg::FLASH_ON_MS * sli_pkg::MS_CYCLES,
    parameter int unsigned FLASH_OFF_CYC  = sli_pkg::FLASH_OFF_MS * sli_pkg::MS_CYCLES,
    parameter int unsigned PAUSE_CYC      = sli_pkg::GROUP_PAUSE_MS * sli_pkg::MS_CYCLES,
    parameter int unsigned FAST_HALF_CYC  = sli_pkg::FAST_HALF_MS * sli_pkg::MS_CYCLES,
    parameter int unsigned ACT_HOLD_CYC   = sli_pkg::ACT_HOLD_MS * sli_pkg::MS_CYCLES
)
(
    input  wire logic                  i_clk,
    input  wire logic                  i_sys_rst,
    input  wire sli_pkg::sli_status_t  i_status,
    input  wire logic                  i_corr_msg_stb,
    input  wire logic                  i_gp_func_we,
    input  wire sli_pkg::sli_gp_func_t i_gp_func,
    input  wire logic                  i_power_mode_command,
    input  wire logic                  i_wakeup_serial_port_rx,
    input  wire logic                  i_power_fail,
    output var  sli_pkg::sli_lamps_t   o_lamps,
    output var  logic                  o_standby,
    output var  logic                  o_card_write_enable
);
    import sli_pkg::*;

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [CNT_W-1:0] ms_cnt_r;
    logic [CNT_W-1:0] ms_cnt_nxt;
    logic             ms_tick;

    always_comb
    begin
        ms_tick    = (ms_cnt_r == CNT_W'(MS_CYCLES - 1));
        ms_cnt_nxt = ms_tick ? '0 : ms_cnt_r + 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ms_cnt_r <= '0;
        else
            ms_cnt_r <= ms_cnt_nxt;
    end

    // ------------------------------------------------------------
    // serial wake-up pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] rx_sync_r;
    logic       rx_level_r;
    logic       rx_level_nxt;
    logic       rx_edge;

    always_comb
    begin
        // a change counts once the second and third stages agree
        rx_level_nxt = (rx_sync_r[1] == rx_sync_r[2]) ? rx_sync_r[2] : rx_level_r;
        // a start bit pulls the idle-high line low
        rx_edge      = rx_level_r & ~rx_level_nxt;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rx_sync_r  <= 3'h7;
            rx_level_r <= 1'b1;
        end
        else
        begin
            rx_sync_r  <= {rx_sync_r[1:0], i_wakeup_serial_port_rx};
            rx_level_r <= rx_level_nxt;
        end
    end

    // ------------------------------------------------------------
    // stand-by control
    // ------------------------------------------------------------
    logic standby_r;
    logic standby_nxt;

    always_comb
    begin
        standby_nxt = standby_r;
        if (i_power_mode_command)
            standby_nxt = 1'b1;
        if (standby_r && rx_edge)
            standby_nxt = 1'b0;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            standby_r <= 1'b0;
        else
            standby_r <= standby_nxt;
    end

    // ------------------------------------------------------------
    // correction capture and lamp function select
    // ------------------------------------------------------------
    logic         corr_seen_r;
    logic         corr_seen_nxt;
    logic [7:0]   corr_sats_r;
    logic [7:0]   corr_sats_nxt;
    sli_gp_func_t gp_func_r;
    sli_gp_func_t gp_func_nxt;

    always_comb
    begin
        corr_seen_nxt = corr_seen_r;
        corr_sats_nxt = corr_sats_r;
        gp_func_nxt   = gp_func_r;
        if (i_corr_msg_stb)
        begin
            corr_seen_nxt = 1'b1;
            corr_sats_nxt = i_status.corr_sats;
        end
        if (i_gp_func_we)
            gp_func_nxt = i_gp_func;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            corr_seen_r <= 1'b0;
            corr_sats_r <= SAT_RESET;
            gp_func_r   <= sli_gp_func_t'(GP_FUNC_RESET);
        end
        else
        begin
            corr_seen_r <= corr_seen_nxt;
            corr_sats_r <= corr_sats_nxt;
            gp_func_r   <= gp_func_nxt;
        end
    end

    // ------------------------------------------------------------
    // network activity stretch
    // ------------------------------------------------------------
    logic [CNT_W-1:0] act_ms_r;
    logic [CNT_W-1:0] act_ms_nxt;
    logic             act_on_r;
    logic             act_on_nxt;

    always_comb
    begin
        act_ms_nxt = act_ms_r;
        act_on_nxt = act_on_r;
        // toggle while traffic lasts, so a steady stream still blinks
        if (ms_tick)
        begin
            if (act_ms_r >= CNT_W'(ACT_HOLD_CYC / MS_CYCLES - 1))
            begin
                act_ms_nxt = '0;
                act_on_nxt = i_status.eth_frame ? ~act_on_r : 1'b0;
            end
            else
                act_ms_nxt = act_ms_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            act_ms_r <= '0;
            act_on_r <= 1'b0;
        end
        else
        begin
            act_ms_r <= act_ms_nxt;
            act_on_r <= act_on_nxt;
        end
    end

    // ------------------------------------------------------------
    // blink-group encoders
    // ------------------------------------------------------------
    function automatic logic [2:0] sli_groups(input logic [7:0] sats);
        logic [7:0] half;
        // widen first, so a count of 255 does not wrap to zero
        half = 8'(({1'b0, sats} + 9'h001) >> 1);
        // pairs of counts, capped at five
        sli_groups = (half >= 8'(GROUPS_MAX)) ? GROUPS_MAX : half[2:0];
    endfunction

    logic corr_blink;
    logic track_blink;

    sli_blink_group #(
        .FLASH_ON_MS (FLASH_ON_CYC / MS_CYCLES),
        .FLASH_OFF_MS(FLASH_OFF_CYC / MS_CYCLES),
        .PAUSE_MS    (PAUSE_CYC / MS_CYCLES),
        .FAST_HALF_MS(FAST_HALF_CYC / MS_CYCLES)
    ) u_corr_blink (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ms_tick(ms_tick),
        .i_zero   (corr_sats_r == SAT_RESET),
        .i_groups (sli_groups(corr_sats_r)),
        .o_lamp   (corr_blink)
    );

    sli_blink_group #(
        .FLASH_ON_MS (FLASH_ON_CYC / MS_CYCLES),
        .FLASH_OFF_MS(FLASH_OFF_CYC / MS_CYCLES),
        .PAUSE_MS    (PAUSE_CYC / MS_CYCLES),
        .FAST_HALF_MS(FAST_HALF_CYC / MS_CYCLES)
    ) u_track_blink (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ms_tick(ms_tick),
        .i_zero   (i_status.track_sats == SAT_RESET),
        .i_groups (sli_groups(i_status.track_sats)),
        .o_lamp   (track_blink)
    );

    // ------------------------------------------------------------
    // lamp outputs
    // ------------------------------------------------------------
    sli_lamps_t lamps_nxt;
    logic       corr_lamp;
    logic       card_we_nxt;

    always_comb
    begin
        if (i_status.base_station)
            corr_lamp = 1'b1;
        else if (!corr_seen_r)
            corr_lamp = 1'b0;
        // zero count fast blink, handled in encoder
        else
            corr_lamp = corr_blink;

        lamps_nxt.power_indicator            = i_status.powered_on;
        lamps_nxt.network_activity_indicator = act_on_r;
        lamps_nxt.logging_indicator          = i_status.card_write;
        lamps_nxt.position_fix_indicator     = i_status.pvt_valid;
        lamps_nxt.correction_count_indicator = corr_lamp;
        lamps_nxt.tracking_indicator         = track_blink;
        unique case (gp_func_r)
            SLI_GP_CORRECTION: lamps_nxt.general_purpose_indicator = corr_lamp;
            SLI_GP_TRACKING:   lamps_nxt.general_purpose_indicator = track_blink;
            SLI_GP_FIX:        lamps_nxt.general_purpose_indicator = i_status.pvt_valid;
            SLI_GP_OFF:        lamps_nxt.general_purpose_indicator = 1'b0;
        endcase
        // stand-by darkens every lamp except power, on the edge that raises o_standby
        if (standby_nxt)
            lamps_nxt = '{power_indicator: i_status.powered_on, default: 1'b0};
        // cut card writes at once on power loss or stand-by
        card_we_nxt = i_status.card_write & ~i_power_fail & ~standby_nxt;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_lamps             <= '0;
            o_standby           <= 1'b0;
            o_card_write_enable <= 1'b0;
        end
        else
        begin
            o_lamps             <= lamps_nxt;
            o_standby           <= standby_nxt;
            o_card_write_enable <= card_we_nxt;
        end
    end
endmodule

// one blink-group encoder, counted in millisecond ticks
module sli_blink_group
#(
    parameter int unsigned FLASH_ON_MS  = 150,
    parameter int unsigned FLASH_OFF_MS = 250,
    parameter int unsigned PAUSE_MS     = 1200,
    parameter int unsigned FAST_HALF_MS = 50
)
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_ms_tick,
    input  wire logic       i_zero,
    input  wire logic [2:0] i_groups,
    output var  logic       o_lamp
);
    import sli_pkg::*;

    typedef enum logic [1:0] {ST_ON, ST_OFF, ST_PAUSE, ST_FAST} sli_blink_st_t;

    sli_blink_st_t    st_r;
    sli_blink_st_t    st_nxt;
    logic [CNT_W-1:0] t_r;
    logic [CNT_W-1:0] t_nxt;
    logic [2:0]       n_r;
    logic [2:0]       n_nxt;
    logic             done;

    always_comb
    begin
        st_nxt = st_r;
        t_nxt  = t_r;
        n_nxt  = n_r;
        done   = 1'b0;
        if (i_ms_tick)
        begin
            t_nxt = t_r + 1'b1;
            unique case (st_r)
                ST_ON:    done = (t_r >= CNT_W'(FLASH_ON_MS - 1));
                // zero count uses the short off phase
                ST_OFF:   done = (t_r >= CNT_W'((i_zero ? FAST_HALF_MS : FLASH_OFF_MS) - 1));
                ST_PAUSE: done = (t_r >= CNT_W'(PAUSE_MS - 1));
                ST_FAST:  done = (t_r >= CNT_W'(FAST_HALF_MS - 1));
            endcase
        end
        if (done)
        begin
            t_nxt = '0;
            unique case (st_r)
                ST_ON:    st_nxt = ST_OFF;
                ST_OFF:
                begin
                    // pause only after the last flash of the group
                    st_nxt = (n_r + 3'h1 >= i_groups) ? ST_PAUSE : ST_ON;
                    n_nxt  = n_r + 3'h1;
                end
                ST_PAUSE:
                begin
                    st_nxt = ST_ON;
                    n_nxt  = '0;
                end
                ST_FAST:  st_nxt = ST_ON;
            endcase
        end
        // zero count: 50 ms on, 50 ms off gives ten flashes a second
        if (i_zero && done && st_r == ST_FAST)
            st_nxt = ST_OFF;
        else if (i_zero && st_r != ST_FAST && (st_r == ST_PAUSE || done))
        begin
            st_nxt = ST_FAST;
            t_nxt  = '0;
        end
        else if (i_zero && done && st_r == ST_OFF)
            st_nxt = ST_FAST;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_r   <= ST_PAUSE;
            t_r    <= '0;
            n_r    <= '0;
            o_lamp <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            t_r    <= t_nxt;
            n_r    <= n_nxt;
            o_lamp <= (st_nxt == ST_ON) || (st_nxt == ST_FAST);
        end
    end
endmodule

`default_nettype wire

//--- sli_status_led_indicator_tb.sv
// testbench: directed scenarios for the status lamp indicator
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin fail_count++; \
    $display("CHECK FAILED t=%0t %s", $time, msg); end end
module sli_status_led_indicator_tb;
    import sli_pkg::*;
    logic         i_clk;
    logic         i_sys_rst;
    sli_status_t  st;
    logic         stb;
    logic         gp_we;
    sli_gp_func_t gp_func;
    logic         cmd;
    logic         pf;
    logic         send;
    logic         rx;
    logic         busy;
    int unsigned  rises;
    sli_lamps_t   lamps;
    logic         standby;
    logic         cwe;
    int           fail_count;
    int           checked;
    // one-millisecond fast blink and network hold keep the run short
    sli_status_led_indicator #(.FAST_HALF_CYC(MS_CYCLES), .ACT_HOLD_CYC(MS_CYCLES)) i_dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_status(st),
        .i_corr_msg_stb(stb), .i_gp_func_we(gp_we), .i_gp_func(gp_func),
        .i_power_mode_command(cmd), .i_wakeup_serial_port_rx(rx), .i_power_fail(pf),
        .o_lamps(lamps), .o_standby(standby), .o_card_write_enable(cwe));
    sli_panel_model i_panel (.i_clk(i_clk), .i_lamps(lamps), .i_send(send), .o_rx(rx),
        .o_busy(busy), .o_rises(rises));
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // bounded wait: a stuck frame ends the run
    task automatic send_char();
        @(posedge i_clk);
        send <= 1'b1;
        @(posedge i_clk);
        send <= 1'b0;
        for (int n = 0; n < 200 && (n < 2 || busy); n++)
            tick(1);
        if (busy)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t serial frame stuck", $time);
            finish_test();
        end
    endtask
    task automatic t_steady();
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            st.card_write <= k[1];
            st.pvt_valid <= k[0];
            tick(1);
            `CHK(lamps.logging_indicator, k[1], "logging lamp")
            `CHK(lamps.position_fix_indicator, k[0], "fix lamp")
            `CHK(cwe, k[1], "card write enable")
            `CHK(lamps.network_activity_indicator, 1'b0, "network lamp idle")
        end
        @(posedge i_clk);
        pf <= 1'b1;
        st.powered_on <= 1'b0;
        tick(1);
        `CHK(cwe, 1'b0, "card write in power loss")
        `CHK(lamps.power_indicator, 1'b0, "power lamp off")
        @(posedge i_clk);
        pf <= 1'b0;
        st.powered_on <= 1'b1;
        tick(1);
        `CHK(lamps.power_indicator, 1'b1, "power lamp on")
        $display("test steady done");
    endtask
    task automatic t_corr_gp();
        `CHK(lamps.correction_count_indicator, 1'b0, "no message yet")
        `CHK(lamps.general_purpose_indicator, 1'b0, "gp default dark")
        @(posedge i_clk);
        st.base_station <= 1'b1;
        st.corr_sats <= 8'h03;
        stb <= 1'b1;
        @(posedge i_clk);
        stb <= 1'b0;
        tick(1);
        `CHK(lamps.correction_count_indicator, 1'b1, "base lamp solid")
        `CHK(lamps.general_purpose_indicator, 1'b1, "gp shows correction")
        tick(200);
        `CHK(rises, 1, "base lamp flickered")
        // off, fix, tracking, correction; fix shows pvt_valid, still high
        for (int k = 3; k >= 0; k--)
        begin
            @(posedge i_clk);
            gp_func <= sli_gp_func_t'(k);
            gp_we <= 1'b1;
            @(posedge i_clk);
            gp_we <= 1'b0;
            tick(1);
            if (k != 1)
                `CHK(lamps.general_purpose_indicator, k != 3, "gp function")
        end
        @(posedge i_clk);
        st.base_station <= 1'b0;
        $display("test correction done");
    endtask
    task automatic t_standby();
        send_char();
        `CHK(standby, 1'b0, "woke while awake")
        @(posedge i_clk);
        cmd <= 1'b1;
        @(posedge i_clk);
        cmd <= 1'b0;
        tick(0);
        `CHK(standby, 1'b1, "standby entry")
        `CHK(lamps[5:0], 6'h00, "lamps dark in standby")
        `CHK(lamps.power_indicator, 1'b1, "power lamp in standby")
        `CHK(cwe, 1'b0, "card closed in standby")
        send_char();
        `CHK(standby, 1'b0, "wake on serial")
        `CHK(lamps.position_fix_indicator, 1'b1, "fix lamp back")
        @(posedge i_clk);
        cmd <= 1'b1;
        @(posedge i_clk);
        cmd <= 1'b0;
        i_sys_rst <= 1'b1;
        tick(3);
        `CHK(standby, 1'b0, "standby cleared by reset")
        `CHK(lamps, 7'h00, "lamps dark in reset")
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        tick(2);
        `CHK(lamps.power_indicator, 1'b1, "power lamp after reset")
        $display("test standby done");
    endtask
    // every lamp below toggles once per millisecond tick of 20000 cycles
    task automatic t_blink();
        sli_lamps_t prev;
        int         n_trk = 0;
        int         n_corr = 0;
        int         n_net = 0;
        @(posedge i_clk);
        st.eth_frame <= 1'b1;
        st.corr_sats <= 8'h00;
        stb <= 1'b1;
        @(posedge i_clk);
        stb <= 1'b0;
        tick(2);
        prev = lamps;
        repeat (45000)
        begin
            tick(1);
            n_trk += (lamps.tracking_indicator != prev.tracking_indicator);
            n_corr += (lamps.correction_count_indicator != prev.correction_count_indicator);
            n_net += (lamps.network_activity_indicator != prev.network_activity_indicator);
            prev = lamps;
        end
        `CHK(n_trk >= 2 && n_trk <= 3, 1'b1, "tracking fast blink")
        `CHK(n_corr >= 2 && n_corr <= 3, 1'b1, "zero count fast blink")
        `CHK(n_net >= 2 && n_net <= 3, 1'b1, "network lamp blinks")
        @(posedge i_clk);
        st.eth_frame <= 1'b0;
        tick(20002);
        `CHK(lamps.network_activity_indicator, 1'b0, "network lamp off")
        $display("test blink done");
    endtask
    initial
    begin
        fail_count = 0;
        checked = 0;
        i_sys_rst = 1'b1;
        st = '0;
        st.powered_on = 1'b1;
        stb = 1'b0;
        gp_we = 1'b0;
        gp_func = SLI_GP_CORRECTION;
        cmd = 1'b0;
        pf = 1'b0;
        send = 1'b0;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        tick(2);
        t_steady();
        t_corr_gp();
        t_standby();
        t_blink();
        finish_test();
    end
endmodule
`default_nettype wire
